// [hdl/msb_defs.svh]
`ifndef MSB_DEFS_SVH
`define MSB_DEFS_SVH

// ----------------------------------------------------------------
// Instruction capture and address codes
// ----------------------------------------------------------------
`define MSB_IR_CAPTURE_LOW  2'b01
`define MSB_ADDR_INDIV_MAX  8'h3a
`define MSB_ADDR_BCAST      8'h3b
`define MSB_ADDR_GROUP_BASE 8'h3c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MSB_GRP_RESET       2'h0
`define MSB_PCFG_RESET_LOW  7'h01
`define MSB_FLAG_RESET      1'b0
`define MSB_BYPASS_CAPTURE  1'b0

// ----------------------------------------------------------------
// Port configuration field positions
// ----------------------------------------------------------------
`define MSB_PCFG_PORT3_BIT  4
`define MSB_PCFG_CLK_BIT    3
`define MSB_PCFG_FLAG_BIT   7

// ----------------------------------------------------------------
// Timing counts and buffering
// ----------------------------------------------------------------
`define MSB_TLR_CLK_PULSES  10'd512
`define MSB_TLR_CNT_W       10
`define MSB_FIFO_DEPTH      16

`endif

// [hdl/msb_pkg.sv]
package msb_pkg;

    // ------------------------------------------------------------
    // Types shared by the bridge registers
    // ------------------------------------------------------------

    // TAP controller state strobes, one per backplane test clock
    typedef struct packed {
        logic tlr;          // In Test-Logic-Reset
        logic capture_ir;   // Leaving Capture-IR
        logic shift_ir;     // In Shift-IR
        logic update_ir;    // In Update-IR
        logic capture_dr;   // Leaving Capture-DR
        logic shift_dr;     // In Shift-DR
        logic update_dr;    // In Update-DR
    } msb_tap_t;

    // Data register picked by the instruction decoder
    typedef enum logic [3:0] {
        MSB_DR_BYPASS   = 4'b0001,
        MSB_DR_BOUNDARY = 4'b0010,
        MSB_DR_GROUP    = 4'b0100,
        MSB_DR_PCFG     = 4'b1000
    } msb_dr_t;

    // Selection state of the bridge
    typedef enum logic [1:0] {
        MSB_WAIT_ADDR = 2'b01,
        MSB_SELECTED  = 2'b10
    } msb_sel_t;

    // Park status from the local port controllers
    typedef struct packed {
        logic [3:0] parked;  // Port parked, one per local port
        logic       in_tlr;  // Ports held in parked_in_reset_state
    } msb_park_t;

    // Test clock counter status
    typedef struct packed {
        logic on;      // Counter enabled
        logic zero;    // Counter at terminal count
        logic reload;  // Counter loaded with a new value
    } msb_cntr_t;

endpackage

// [hdl/msb_bit_fifo.sv]
`timescale 1ns/1ps

module msb_bit_fifo
    import msb_pkg::*;
#(
    parameter int W = 1,
    parameter int D = 16
)
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);

    // ------------------------------------------------------------
    // Storage and pointers (depth must be a power of two)
    // ------------------------------------------------------------
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];       // Word store
    logic [AW-1:0] wr_ptr_r;      // Next slot to write
    logic [AW-1:0] rd_ptr_r;      // Next slot to read
    logic [AW:0]   count_r;       // Words held in the store
    logic [AW:0]   count_nxt;     // Count after this edge
    logic          in_ready_r;    // Room left, registered
    logic          out_valid_r;   // Output stage holds a word
    logic [W-1:0]  out_data_r;    // Output stage word
    wire           push;          // Word accepted this edge
    wire           pop;           // Word moved to output stage

    assign push      = in_valid & in_ready_r;
    assign pop       = (count_r != '0) & (~out_valid_r | out_ready);
    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready  = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;

    // Store write, no reset needed for data
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    // Pointers, count and registered full flag
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_r   <= '0;
            rd_ptr_r   <= '0;
            count_r    <= '0;
            in_ready_r <= 1'b1;
        end
        else
        begin
            wr_ptr_r   <= wr_ptr_r + AW'(push);
            rd_ptr_r   <= rd_ptr_r + AW'(pop);
            count_r    <= count_nxt;
            in_ready_r <= (count_nxt != (AW+1)'(D));
        end
    end

    // Output stage, drained by the far side
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end
        else if (pop)
        begin
            out_valid_r <= 1'b1;
            out_data_r  <= mem[rd_ptr_r];
        end
        else if (out_ready)
            out_valid_r <= 1'b0;
    end

endmodule

// [hdl/msb_bridge_regs.sv]
`timescale 1ns/1ps
`include "msb_defs.svh"

// Summary of operation
// RULE_01: Eight-bit instruction register shifts during Shift-IR
// RULE_02: Capture-IR loads slot levels above binary 01
// RULE_03: Wait-For-Address selects only on address match
// RULE_04: Codes 00 to 3A match slot inputs
// RULE_05: Address 3B selects every bridge
// RULE_06: Group addresses compare against group select register
// RULE_07: Integrator never uses group codes as slots
// RULE_08: Group select register is two bits wide
// RULE_09: Codes 00..11 map to 3C..3F
// RULE_10: Matching group address selects the bridge
// RULE_11: Group select clears in Test-Logic-Reset
// RULE_12: Master programs groups individually, then broadcasts
// RULE_13: Selected bridge offers one-bit bypass path
// RULE_14: Boundary register only samples slot and enable
// RULE_15: Port configuration resets to 00000001
// RULE_16: Bits 0,1,2,4 pick ports; bit 3 clocks
// RULE_17: All parked: register straight to serial output
// RULE_18: Unparked ports join ascending, each with pad
// RULE_19: Parked ports stop clocks when bit 3 set
// RULE_20: Parked reset state stops clocks after 512
// RULE_21: Bit 7 flags counter at zero, read-only
// RULE_22: Failed address match changes nothing

module msb_bridge_regs
    import msb_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire msb_tap_t   tap,
    input  wire logic       tdi,
    input  wire logic       goto_wait,
    input  wire msb_dr_t    dr_sel,
    input  wire logic [6:0] slot,
    input  wire logic       oe_b,
    input  wire msb_park_t  park,
    input  wire msb_cntr_t  cntr,
    input  wire logic [3:0] lsp_tdo,
    output logic      [3:0] lsp_tdi,
    output logic      [3:0] lsp_clk_run,
    output logic            selected,
    output logic      [1:0] group_select,
    output logic      [7:0] port_config,
    output logic            shift_ready,
    output logic            tdo_data,
    output logic            tdo_valid,
    input  wire logic       tdo_ready
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Group address for a group code
    function automatic logic [7:0] group_addr(input logic [1:0] code);
        group_addr = `MSB_ADDR_GROUP_BASE + {6'h00, code};
    endfunction

    // Configuration bit that inserts a given local port
    function automatic int port_bit(input int p);
        port_bit = (p < 3) ? p : `MSB_PCFG_PORT3_BIT;
    endfunction

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    msb_sel_t   sel_r;         // Selection state
    msb_sel_t   sel_nxt;       // Next selection state
    logic [7:0] ir_r;          // Instruction shift register
    logic       byp_r;         // Bypass bit
    logic [7:0] bsr_r;         // Sample-only boundary register
    logic [1:0] grp_sh_r;      // Group select shift stage
    logic [1:0] grp_r;         // Group select register
    logic [7:0] pcfg_sh_r;     // Port configuration shift stage
    logic [6:0] pcfg_r;        // Port configuration, writable bits
    logic       flag_r;        // Counter status flag
    logic [3:0] lsp_tdi_r;     // Feed bit to each local port
    logic [3:0] pad_r;         // Pad stage after each local port
    logic [3:0] clk_run_r;     // Local test clock enables
    logic [`MSB_TLR_CNT_W-1:0] tlr_cnt_r;  // Pulses in parked reset
    logic       sel_out_r;     // Selected flag to the outside

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire        fifo_in_ready; // Room for one more serial bit
    wire        shifting;      // Shift requested by TAP
    wire        adv;           // Shift actually taken
    wire        is_sel;        // Bridge currently selected
    wire        hit_indiv;     // Individual address match
    wire        hit_bcast;     // Broadcast address match
    wire        hit_group;     // Group address match
    wire        addr_hit;      // Any address match
    msb_dr_t    dr_eff;        // Data register in the path
    wire        dr_out;        // Bit leaving the data register
    wire        dr_upd;        // Update of a selected register
    wire [3:0]  in_chain;      // Port inserted in scan chain
    wire        tlr_done;      // 512 pulses seen in parked reset
    wire        cnt_stop;      // Counter holds parked clocks low
    wire        clk_bit;       // Clock control bit
    logic [3:0] feed;          // Bit offered to each port
    logic       chain_end;     // Bit leaving the port network
    wire        fifo_bit;      // Bit pushed to the output buffer

    // Shifting stalls while the output buffer is full
    assign shifting = tap.shift_ir | tap.shift_dr;
    assign adv      = shifting & fifo_in_ready;
    assign is_sel   = (sel_r == MSB_SELECTED);

    // Individual address, codes 00 to 3A against slot inputs
    assign hit_indiv = (ir_r <= `MSB_ADDR_INDIV_MAX) &&
                       (ir_r == {1'b0, slot});         // RULE_04
    // Broadcast address selects every bridge
    assign hit_bcast = (ir_r == `MSB_ADDR_BCAST);      // RULE_05
    // Group address against the group select register
    assign hit_group = (ir_r == group_addr(grp_r));    // RULE_06 RULE_09
    assign addr_hit  = hit_indiv | hit_bcast | hit_group;

    // Unselected bridge offers the bypass bit, then any ports in the chain
    assign dr_eff = is_sel ? dr_sel : MSB_DR_BYPASS;
    assign dr_upd = tap.update_dr & is_sel;

    // Bit leaving whichever data register sits in the path
    assign dr_out = (dr_eff == MSB_DR_BOUNDARY) ? bsr_r[0]     :
                    (dr_eff == MSB_DR_GROUP)    ? grp_sh_r[0]  :
                    (dr_eff == MSB_DR_PCFG)     ? pcfg_sh_r[0] :
                                                  byp_r;

    // Ports join only when enabled and unparked
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++)
        begin : g_chain
            assign in_chain[gp] = pcfg_r[port_bit(gp)] &
                                  ~park.parked[gp];    // RULE_16
        end
    endgenerate

    // Walk the port network in ascending order
    always_comb
    begin
        logic cur;
        cur  = dr_out;
        feed = lsp_tdi_r;
        for (int p = 0; p < 4; p++)
        begin
            if (in_chain[p])
            begin
                feed[p] = cur;                         // RULE_18
                cur     = pad_r[p];
            end
        end
        // With every port parked cur is still dr_out
        chain_end = cur;                               // RULE_17
    end

    // Instruction scan bypasses the port network
    assign fifo_bit = tap.shift_ir ? ir_r[0] : chain_end;

    // Clock gating terms
    assign clk_bit  = pcfg_r[`MSB_PCFG_CLK_BIT];
    assign tlr_done = (tlr_cnt_r == `MSB_TLR_CLK_PULSES);
    assign cnt_stop = cntr.on & cntr.zero;

    // ------------------------------------------------------------
    // Selection state machine
    // ------------------------------------------------------------

    // Next state from address match or return request
    always_comb
    begin
        sel_nxt = sel_r;
        if (tap.tlr)
            sel_nxt = MSB_WAIT_ADDR;
        else
        begin
            case (sel_r)
                MSB_WAIT_ADDR:
                begin
                    // A miss leaves everything as it was
                    if (tap.update_ir && addr_hit)
                        sel_nxt = MSB_SELECTED; // RULE_03 RULE_10 RULE_22
                end
                MSB_SELECTED:
                begin
                    // Deselect on return request
                    if (goto_wait)
                        sel_nxt = MSB_WAIT_ADDR;
                end
                default:
                    sel_nxt = MSB_WAIT_ADDR;
            endcase
        end
    end

    // State register and its registered copy
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_r     <= MSB_WAIT_ADDR;
            sel_out_r <= 1'b0;
        end
        else
        begin
            sel_r     <= sel_nxt;
            sel_out_r <= (sel_nxt == MSB_SELECTED);
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------

    // Capture slot levels, then shift toward the output
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ir_r <= '0;
        else if (tap.capture_ir)
            ir_r <= {1'b0, slot[4:0], `MSB_IR_CAPTURE_LOW}; // RULE_02
        else if (tap.shift_ir && adv)
            ir_r <= {tdi, ir_r[7:1]};                       // RULE_01
    end

    // ------------------------------------------------------------
    // Bypass and boundary registers
    // ------------------------------------------------------------

    // One-bit bypass, captures zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            byp_r <= `MSB_BYPASS_CAPTURE;
        else if (tap.capture_dr && dr_eff == MSB_DR_BYPASS)
            byp_r <= `MSB_BYPASS_CAPTURE;              // RULE_13
        else if (tap.shift_dr && adv && dr_eff == MSB_DR_BYPASS)
            byp_r <= tdi;                              // RULE_13
    end

    // Sample-only cells, no update stage drives anything
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            bsr_r <= '0;
        else if (tap.capture_dr && dr_eff == MSB_DR_BOUNDARY)
            bsr_r <= {oe_b, slot};                     // RULE_14
        else if (tap.shift_dr && adv && dr_eff == MSB_DR_BOUNDARY)
            bsr_r <= {tdi, bsr_r[7:1]};
    end

    // ------------------------------------------------------------
    // Group select register
    // ------------------------------------------------------------

    // Shift stage, captures the current group code
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            grp_sh_r <= `MSB_GRP_RESET;
        else if (tap.capture_dr && dr_eff == MSB_DR_GROUP)
            grp_sh_r <= grp_r;
        else if (tap.shift_dr && adv && dr_eff == MSB_DR_GROUP)
            grp_sh_r <= {tdi, grp_sh_r[1]};            // RULE_08
    end

    // Held code, cleared in Test-Logic-Reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            grp_r <= `MSB_GRP_RESET;
        else if (tap.tlr)
            grp_r <= `MSB_GRP_RESET;                   // RULE_11
        else if (dr_upd && dr_sel == MSB_DR_GROUP)
            grp_r <= grp_sh_r;                         // RULE_08
    end

    // ------------------------------------------------------------
    // Port configuration register
    // ------------------------------------------------------------

    // Shift stage, captures value with status flag
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            pcfg_sh_r <= '0;
        else if (tap.capture_dr && dr_eff == MSB_DR_PCFG)
            pcfg_sh_r <= {flag_r, pcfg_r};
        else if (tap.shift_dr && adv && dr_eff == MSB_DR_PCFG)
            pcfg_sh_r <= {tdi, pcfg_sh_r[7:1]};
    end

    // Writable bits; bit 7 of the shift stage is dropped
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            pcfg_r <= `MSB_PCFG_RESET_LOW;
        else if (tap.tlr)
            pcfg_r <= `MSB_PCFG_RESET_LOW;             // RULE_15
        else if (dr_upd && dr_sel == MSB_DR_PCFG)
            pcfg_r <= pcfg_sh_r[6:0];                  // RULE_16
    end

    // Counter status flag, set wins over reload
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flag_r <= `MSB_FLAG_RESET;
        else if (cnt_stop)
            flag_r <= 1'b1;                            // RULE_21
        else if (cntr.reload)
            flag_r <= 1'b0;                            // RULE_21
    end

    // ------------------------------------------------------------
    // Local port network
    // ------------------------------------------------------------

    // Feed and pad stages move only on a taken shift
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lsp_tdi_r <= '0;
            pad_r     <= '0;
        end
        else if (tap.shift_dr && adv)
        begin
            lsp_tdi_r <= feed;                         // RULE_18
            pad_r     <= lsp_tdo;                      // RULE_18
        end
    end

    // ------------------------------------------------------------
    // Local test clock control
    // ------------------------------------------------------------

    // Count backplane clocks while held in parked reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            tlr_cnt_r <= '0;
        else if (!park.in_tlr)
            tlr_cnt_r <= '0;
        else if (!tlr_done)
            tlr_cnt_r <= tlr_cnt_r + 1'b1;             // RULE_20
    end

    // Unparked ports always run; parked ones may stop
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            clk_run_r <= '1;
        else
        begin
            for (int p = 0; p < 4; p++)
            begin
                if (!park.parked[p])
                    clk_run_r[p] <= 1'b1;
                else if (park.in_tlr)
                    clk_run_r[p] <= ~tlr_done & ~cnt_stop; // RULE_20
                else
                    clk_run_r[p] <= ~clk_bit & ~cnt_stop;  // RULE_19
            end
        end
    end

    // ------------------------------------------------------------
    // Serial output buffer
    // ------------------------------------------------------------

    // Bits leaving the chain wait here for the master
    msb_bit_fifo #(
        .W (1),
        .D (`MSB_FIFO_DEPTH)
    ) u_out_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (adv),
        .in_data   (fifo_bit),
        .in_ready  (fifo_in_ready),
        .out_valid (tdo_valid),
        .out_data  (tdo_data),
        .out_ready (tdo_ready)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign lsp_tdi      = lsp_tdi_r;
    assign lsp_clk_run  = clk_run_r;
    assign selected     = sel_out_r;
    assign group_select = grp_r;
    assign port_config  = {flag_r, pcfg_r};
    assign shift_ready  = fifo_in_ready;

endmodule

// [bench/msb_bridge_regs_assertions.sv]
`timescale 1ns/1ps

// --------------------------------------------------------------
// Port-level checks of the bridge registers
// --------------------------------------------------------------
module msb_bridge_regs_assertions
    import msb_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire msb_tap_t   tap,
    input wire msb_park_t  park,
    input wire msb_cntr_t  cntr,
    input wire logic [3:0] lsp_clk_run,
    input wire logic       selected,
    input wire logic [1:0] group_select,
    input wire logic [7:0] port_config,
    input wire logic       shift_ready,
    input wire logic       tdo_data,
    input wire logic       tdo_valid,
    input wire logic       tdo_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    grp_reset_a: assert property (tap.tlr |=> group_select == 2'h0)
        else $error("group code kept over reset state");
    cfg_reset_a: assert property (tap.tlr |=> port_config[6:0] == 7'h01)
        else $error("port config not reloaded");
    sel_cause_a: assert property ($rose(selected) |-> $past(tap.update_ir))
        else $error("selected rose without update");
    grp_hold_a: assert property (!selected && !tap.tlr |=> $stable(group_select))
        else $error("group changed while unselected");
    cfg_hold_a: assert property (!selected && !tap.tlr |=> $stable(port_config[6:0]))
        else $error("config changed while unselected");
    flag_set_a: assert property (cntr.on && cntr.zero |=> port_config[7])
        else $error("counter flag not set");
    flag_clr_a: assert property (cntr.reload && !cntr.zero |=> !port_config[7])
        else $error("counter flag not cleared");
    clk_run_a: assert property (park.parked == 4'h0 |=> lsp_clk_run == 4'hf)
        else $error("unparked clock stopped");
    clk_stop_a: assert property (&park.parked && !park.in_tlr && port_config[3]
        |=> lsp_clk_run == 4'h0)
        else $error("parked clock still running");
    out_hold_a: assert property (tdo_valid && !tdo_ready |=> tdo_valid && $stable(tdo_data))
        else $error("serial output dropped while stalled");

    cover property ($rose(selected));
    cover property (tap.tlr);
    cover property (!shift_ready);
endmodule

// [bench/msb_lsp_model.sv]
`timescale 1ns/1ps

// --------------------------------------------------------------
// Local scan chains, one stage each, shifting only on a live clock
// --------------------------------------------------------------
module msb_lsp_model
(
    input  wire logic       clk,
    input  wire logic [3:0] lsp_tdi,
    input  wire logic [3:0] lsp_clk_run,
    output logic      [3:0] lsp_tdo
);
    initial lsp_tdo = 4'h0;
    // Stopped chains hold their stage
    always @(posedge clk)
        lsp_tdo <= (lsp_tdi & lsp_clk_run) | (lsp_tdo & ~lsp_clk_run);
endmodule

// [bench/msb_bridge_regs_tb.sv]
`timescale 1ns/1ps

// --------------------------------------------------------------
// Bench for the bridge registers
// --------------------------------------------------------------
module msb_bridge_regs_tb import msb_pkg::*;;
    logic clk, rst_b, tdi, goto_wait, oe_b, tdo_ready;
    msb_tap_t tap;
    msb_dr_t dr_sel;
    msb_park_t park;
    msb_cntr_t cntr;
    logic [6:0] slot;
    logic [3:0] lsp_tdo, lsp_tdi, lsp_clk_run;
    logic selected, shift_ready, tdo_data, tdo_valid;
    logic [1:0] group_select;
    logic [7:0] port_config, got;
    logic q[$];
    int fail_count, compares;

    msb_bridge_regs u_msb_bridge_regs (.clk(clk), .rst_b(rst_b), .tap(tap),
        .tdi(tdi), .goto_wait(goto_wait), .dr_sel(dr_sel), .slot(slot),
        .oe_b(oe_b), .park(park), .cntr(cntr), .lsp_tdo(lsp_tdo),
        .lsp_tdi(lsp_tdi), .lsp_clk_run(lsp_clk_run), .selected(selected),
        .group_select(group_select), .port_config(port_config),
        .shift_ready(shift_ready), .tdo_data(tdo_data),
        .tdo_valid(tdo_valid), .tdo_ready(tdo_ready));
    msb_lsp_model u_msb_lsp_model (.clk(clk), .lsp_tdi(lsp_tdi),
        .lsp_clk_run(lsp_clk_run), .lsp_tdo(lsp_tdo));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Collect every serial bit taken
    always @(posedge clk)
        if (tdo_valid === 1'b1 && tdo_ready === 1'b1) q.push_back(tdo_data);

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("compares=%0d mismatches=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One cycle of TAP state, changed after the falling edge
    task step(input msb_tap_t t, input logic d);
        tap = t;
        tdi = d;
        @(negedge clk);
    endtask

    // Capture, n shifts LSB first, update, then drain the buffer
    task scan(input logic ir, input logic [7:0] v, input int n);
        q.delete();
        step(ir ? 7'h20 : 7'h04, 1'b0);
        for (int i = 0; i < n; i++) step(ir ? 7'h10 : 7'h02, v[i]);
        step(ir ? 7'h08 : 7'h01, 1'b0);
        repeat (5) step(7'h00, 1'b0);
        got = 8'h00;
        foreach (q[i]) got[i] = q[i];
    endtask

    task back_to_wait;
        goto_wait = 1'b1;
        step(7'h00, 1'b0);
        goto_wait = 1'b0;
    endtask

    // Run takes under 1000 cycles; allow three times that
    initial
    begin
        #(25 * 3000);
        fail_count++;
        final_report;
    end

    initial
    begin
        tap = 7'h00; tdi = 1'b0; goto_wait = 1'b0; oe_b = 1'b0;
        dr_sel = MSB_DR_BYPASS; park = 5'h1e; cntr = 3'h0; tdo_ready = 1'b1;
        slot = 7'h15;
        rst_b = 1'b0; fail_count = 0; compares = 0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        chk(selected, 1'b0);
        chk(group_select, 2'h0);
        chk(port_config, 8'h01);
        scan(1'b1, 8'h14, 8);
        chk(got, 8'h55);
        chk(selected, 1'b0);
        scan(1'b1, 8'h15, 8);
        chk(selected, 1'b1);
        dr_sel = MSB_DR_BOUNDARY;
        scan(1'b0, 8'h00, 8);
        chk(got, {oe_b, slot});
        dr_sel = MSB_DR_GROUP;
        scan(1'b0, 8'h02, 2);
        chk(group_select, 2'h2);
        dr_sel = MSB_DR_PCFG;
        scan(1'b0, 8'h8f, 8);
        chk(got, 8'h01);
        chk(port_config, 8'h0f);
        chk(lsp_clk_run, 4'h0);
        dr_sel = MSB_DR_BYPASS;
        scan(1'b0, 8'h35, 8);
        chk(got, 8'h6a);
        park.parked = 4'h0;
        scan(1'b0, 8'hff, 8);
        chk(lsp_clk_run, 4'hf);
        chk(lsp_tdi, 4'h7);
        park.parked = 4'hf;
        $display("select test done");
        for (int g = 0; g < 4; g++)
        begin
            back_to_wait();
            scan(1'b1, 8'h3c + 8'(g), 8);
            chk(selected, 8'(g == 2));
        end
        back_to_wait();
        scan(1'b1, 8'h3b, 8);
        chk(selected, 1'b1);
        $display("group and broadcast test done");
        cntr = 3'h6;
        repeat (2) step(7'h00, 1'b0);
        chk(port_config[7], 1'b1);
        cntr = 3'h1;
        repeat (2) step(7'h00, 1'b0);
        chk(port_config[7], 1'b0);
        cntr = 3'h0;
        step(7'h40, 1'b0);
        step(7'h00, 1'b0);
        chk(selected, 1'b0);
        chk(group_select, 2'h0);
        chk(port_config, 8'h01);
        $display("flag and reset test done");
        park.in_tlr = 1'b1;
        repeat (500) step(7'h00, 1'b0);
        chk(lsp_clk_run, 4'hf);
        repeat (20) step(7'h00, 1'b0);
        chk(lsp_clk_run, 4'h0);
        park.in_tlr = 1'b0;
        $display("parked clock test done");
        tdo_ready = 1'b0;
        step(7'h20, 1'b0);
        repeat (20) step(7'h10, 1'b1);
        chk(shift_ready, 1'b0);
        q.delete();
        tdo_ready = 1'b1;
        repeat (25) step(7'h00, 1'b0);
        chk(8'(q.size()), 8'd17);
        $display("buffer test done");
        final_report;
    end
endmodule

bind msb_bridge_regs msb_bridge_regs_assertions u_msb_bridge_regs_assertions (
    .clk(clk), .rst_b(rst_b), .tap(tap), .park(park), .cntr(cntr),
    .lsp_clk_run(lsp_clk_run), .selected(selected),
    .group_select(group_select), .port_config(port_config),
    .shift_ready(shift_ready), .tdo_data(tdo_data), .tdo_valid(tdo_valid),
    .tdo_ready(tdo_ready));
